/* File: hdl/tacc_thermal_ctrl.sv */
// Function
// - The block waits the programmed interval count of clocks before sampling.
// - Compares run only with enable set and at least one threshold valid.
// - With both thresholds valid, compares alternate and each raises its flag.
// - The registers are decoded at register numbers 1020, 1021 and 1022.
// - Crossed flag and its valid flag are read-only to software.
// - Sensor is compared with a seven-bit threshold in one degree steps.
// - Direction clear flags above threshold, set flags below threshold.
// - Interrupt needs irq enable and external mask; flags record regardless.
// - Writes clear valid flags and restart the comparison.
`include "tacc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module tacc_thermal_ctrl (
	input wire logic clk,
	input wire logic reset,
	input wire logic spr_write,
	input wire logic spr_read,
	input wire tacc_pkg::tacc_spr_t spr_num,
	input wire tacc_pkg::tacc_word_t spr_wdata,
	output logic [31:0] spr_rdata,
	output logic spr_hit,
	input wire logic [6:0] sensor_temp,
	output logic [6:0] dac_threshold,
	input wire logic external_irq_mask,
	output logic thermal_irq
);
	import tacc_pkg::*;

	tacc_word_t thr_q [2];
	tacc_word_t thr_d [2];
	tacc_word_t ctrl_q, ctrl_d;
	tacc_state_t state_q, state_d;
	tacc_count_t cnt_q, cnt_d;
	logic sel_q, sel_d;
	logic [6:0] dac_q, dac_d;
	logic [31:0] rd_q, rd_d;
	logic hit_q, hit_d;
	logic [6:0] temp_s1_q, temp_s2_q, temp_s3_q, temp_held_q;
	logic mask_s1_q, mask_s2_q;
	logic [1:0] wr_thr;
	logic wr_ctrl;
	logic run, any_valid, both_valid;

	// Decode reused by read and write paths
	function automatic logic [1:0] spr_index(input tacc_spr_t n);
		case (n)
			`TACC_SPR_UPPER: spr_index = 2'h0;
			`TACC_SPR_LOWER: spr_index = 2'h1;
			`TACC_SPR_CTRL: spr_index = 2'h2;
			default: spr_index = 2'h3;
		endcase
	endfunction : spr_index

	function automatic logic restart_any();
		restart_any = wr_ctrl | (|wr_thr);
	endfunction : restart_any

	// Analog result is asynchronous, so two flops first
	always_ff @(posedge clk) begin
		temp_s1_q <= sensor_temp;
		temp_s2_q <= temp_s1_q;
		temp_s3_q <= temp_s2_q;
		// Bits may skew through the flops; take a value only once seen twice
		if (temp_s2_q == temp_s3_q) begin
			temp_held_q <= temp_s3_q;
		end
		mask_s1_q <= external_irq_mask;
		mask_s2_q <= mask_s1_q;
	end

	assign wr_ctrl = spr_write && spr_index(spr_num) == 2'h2;
	assign any_valid = thr_q[0][`TACC_THR_VALID_BIT] |
		thr_q[1][`TACC_THR_VALID_BIT];
	assign both_valid = thr_q[0][`TACC_THR_VALID_BIT] &
		thr_q[1][`TACC_THR_VALID_BIT];
	assign run = ctrl_q[`TACC_ENABLE_BIT] && any_valid;

	// Compare sequencer
	always_comb begin
		logic restart;
		restart = wr_ctrl | (|wr_thr);
		state_d = state_q;
		cnt_d = cnt_q;
		sel_d = sel_q;
		if (!both_valid) begin
			sel_d = !thr_q[0][`TACC_THR_VALID_BIT];
		end
		case (state_q)
			TACC_IDLE: begin
				if (run) begin
					state_d = TACC_WAIT;
					cnt_d = ctrl_q[`TACC_INTERVAL_HI:`TACC_INTERVAL_LO];
				end
			end
			TACC_WAIT: begin
				if (cnt_q <= `TACC_ONE_COUNT) begin
					state_d = TACC_SAMPLE;
				end else begin
					cnt_d = cnt_q - `TACC_ONE_COUNT;
				end
			end
			TACC_SAMPLE: begin
				state_d = TACC_WAIT;
				cnt_d = ctrl_q[`TACC_INTERVAL_HI:`TACC_INTERVAL_LO];
				if (both_valid) begin
					sel_d = !sel_q;
				end
			end
			default: state_d = TACC_IDLE;
		endcase
		if (!run || restart) begin
			state_d = TACC_IDLE;
		end
		dac_d = thr_d[sel_d][`TACC_THR_HI:`TACC_THR_LO];
	end

	// Register file and flag updates
	generate
		for (genvar i = 0; i < 2; i++) begin : g_thr
			assign wr_thr[i] = spr_write && spr_index(spr_num) == 2'(i);
			always_comb begin
				logic above, below, hit;
				above = temp_held_q > thr_q[i][`TACC_THR_HI:`TACC_THR_LO];
				below = temp_held_q < thr_q[i][`TACC_THR_HI:`TACC_THR_LO];
				hit = thr_q[i][`TACC_DIR_BIT] ? below : above;
				thr_d[i] = thr_q[i];
				if (state_q == TACC_SAMPLE && sel_q == 1'(i)) begin
					thr_d[i][`TACC_CROSSED_BIT] = hit;
					thr_d[i][`TACC_VALID_FLAG_BIT] = 1'b1;
				end
				if (wr_thr[i]) begin
					// Status bits kept, valid flag dropped
					thr_d[i] = (spr_wdata & `TACC_THR_WRITE_MASK) |
						(thr_q[i] & ~`TACC_THR_WRITE_MASK);
					thr_d[i][`TACC_VALID_FLAG_BIT] = 1'b0;
				end
				if (wr_ctrl) begin
					thr_d[i][`TACC_VALID_FLAG_BIT] = 1'b0;
				end
			end
		end
	endgenerate

	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			// Reserved bits held at zero regardless of software
			ctrl_d = spr_wdata & `TACC_CTRL_WRITE_MASK;
		end
		hit_d = spr_read && spr_index(spr_num) != 2'h3;
		case (spr_index(spr_num))
			2'h0: rd_d = thr_q[0];
			2'h1: rd_d = thr_q[1];
			2'h2: rd_d = ctrl_q;
			default: rd_d = `TACC_ZERO_WORD;
		endcase
		if (!spr_read) begin
			rd_d = `TACC_ZERO_WORD;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			thr_q[0] <= `TACC_ZERO_WORD;
			thr_q[1] <= `TACC_ZERO_WORD;
			ctrl_q <= `TACC_ZERO_WORD;
			state_q <= TACC_IDLE;
			cnt_q <= `TACC_ZERO_COUNT;
			sel_q <= 1'b0;
			dac_q <= `TACC_ZERO_TEMP;
			rd_q <= `TACC_ZERO_WORD;
			hit_q <= 1'b0;
		end else begin
			thr_q[0] <= thr_d[0];
			thr_q[1] <= thr_d[1];
			ctrl_q <= ctrl_d;
			state_q <= state_d;
			cnt_q <= cnt_d;
			sel_q <= sel_d;
			dac_q <= dac_d;
			rd_q <= rd_d;
			hit_q <= hit_d;
		end
	end

	assign spr_rdata = rd_q;
	assign spr_hit = hit_q;
	assign dac_threshold = dac_q;

	// Level interrupt; any valid armed crossing asserts it while the synchronized external mask is high
	always_comb begin
		thermal_irq = 1'b0;
		for (int i = 0; i < 2; i++) begin
			if (thr_q[i][`TACC_THR_VALID_BIT] && thr_q[i][`TACC_IRQEN_BIT] &&
				thr_q[i][`TACC_VALID_FLAG_BIT] && thr_q[i][`TACC_CROSSED_BIT]) begin
				thermal_irq = mask_s2_q;
			end
		end
	end

	sample_needs_run_a: assert property (@(posedge clk) disable iff (reset)
		state_q == TACC_SAMPLE |-> $past(run))
		else $error("sample taken while compare disabled");
	ctrl_write_clears_a: assert property (@(posedge clk) disable iff (reset)
		wr_ctrl |=> !thr_q[0][`TACC_VALID_FLAG_BIT] &&
		!thr_q[1][`TACC_VALID_FLAG_BIT])
		else $error("control write left a valid flag");
	thr_write_restart_a: assert property (@(posedge clk) disable iff (reset)
		|wr_thr |=> state_q == TACC_IDLE)
		else $error("threshold write did not restart");
	interval_wait_a: assert property (@(posedge clk) disable iff (reset)
		$rose(state_q == TACC_WAIT) && cnt_q > `TACC_ONE_COUNT
		|=> state_q != TACC_SAMPLE)
		else $error("sample before interval ended");
	dual_alternate_a: assert property (@(posedge clk) disable iff (reset)
		state_q == TACC_SAMPLE && both_valid && !restart_any()
		|=> sel_q != $past(sel_q))
		else $error("dual mode did not alternate");
	status_readonly_a: assert property (@(posedge clk) disable iff (reset)
		wr_thr[0] && state_q != TACC_SAMPLE |=>
		thr_q[0][`TACC_CROSSED_BIT] == $past(thr_q[0][`TACC_CROSSED_BIT]))
		else $error("crossed flag written by software");
	irq_masked_a: assert property (@(posedge clk) disable iff (reset)
		!mask_s2_q |-> !thermal_irq)
		else $error("interrupt raised while masked");
	reload_after_a: assert property (@(posedge clk) disable iff (reset)
		state_q == TACC_SAMPLE && run && !restart_any() |=>
		state_q == TACC_WAIT &&
		cnt_q == $past(ctrl_q[`TACC_INTERVAL_HI:`TACC_INTERVAL_LO]))
		else $error("interval not reloaded after sample");
	sample_sets_valid_a: assert property (@(posedge clk) disable iff (reset)
		state_q == TACC_SAMPLE && !restart_any() |=>
		thr_q[$past(sel_q)][`TACC_VALID_FLAG_BIT])
		else $error("sample did not validate flag");
endmodule : tacc_thermal_ctrl
`default_nettype wire

/* File: common/tacc_cfg.svh */
`ifndef TACC_CFG_SVH
`define TACC_CFG_SVH
// Register numbers of the special-purpose register port
`define TACC_SPR_UPPER 10'h3FC
`define TACC_SPR_LOWER 10'h3FD
`define TACC_SPR_CTRL 10'h3FE
// Threshold register fields, bit 0 is the LSB of the data word
`define TACC_CROSSED_BIT 31
`define TACC_VALID_FLAG_BIT 30
`define TACC_THR_HI 29
`define TACC_THR_LO 23
`define TACC_DIR_BIT 2
`define TACC_IRQEN_BIT 1
`define TACC_THR_VALID_BIT 0
// Control register fields
`define TACC_INTERVAL_HI 13
`define TACC_INTERVAL_LO 1
`define TACC_ENABLE_BIT 0
`define TACC_THR_WRITE_MASK 32'h3F800007
`define TACC_CTRL_WRITE_MASK 32'h00003FFF
`define TACC_ZERO_WORD 32'h00000000
`define TACC_ZERO_COUNT 13'h0000
`define TACC_ONE_COUNT 13'h0001
`define TACC_ZERO_TEMP 7'h00
`endif

/* File: common/tacc_pkg.sv */
`default_nettype none
package tacc_pkg;
	typedef logic [31:0] tacc_word_t;
	typedef logic [9:0] tacc_spr_t;
	typedef logic [6:0] tacc_temp_t;
	typedef logic [12:0] tacc_count_t;
	typedef enum logic [2:0] {
		TACC_IDLE = 3'b001,
		TACC_WAIT = 3'b010,
		TACC_SAMPLE = 3'b100
	} tacc_state_t;
endpackage : tacc_pkg
`default_nettype wire

/* File: tb/tacc_sensor_model.sv */
`timescale 1ns/100ps
`default_nettype none
module tacc_sensor_model (
	input wire logic clk,
	input wire logic [6:0] junction_temp,
	input wire logic [6:0] dac_threshold,
	output logic [6:0] sensor_temp
);
	// Whole degrees only, so edge cases stay exact
	always_ff @(posedge clk) begin
		sensor_temp <= junction_temp;
	end
endmodule : tacc_sensor_model
`default_nettype wire

/* File: tb/tacc_thermal_ctrl_tb.sv */
`include "tacc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
$display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module tacc_thermal_ctrl_tb;
	import tacc_pkg::*;
	logic clk = 0, reset = 1, spr_write = 0, spr_read = 0, mask = 0;
	tacc_spr_t spr_num = 10'h000;
	tacc_word_t spr_wdata = 32'h00000000;
	logic [31:0] spr_rdata;
	logic spr_hit, thermal_irq, seen_lo = 0;
	logic [6:0] sensor_temp, dac_threshold, temp = 7'h00;
	int err_total = 0, compares = 0, cycles = 0;
	// Status bit patterns of a threshold word
	localparam tacc_word_t fl_both = 32'hC0000000;
	localparam tacc_word_t fl_valid = 32'h40000000;
	localparam tacc_word_t fl_old = 32'h80000000;
	always #5 clk = ~clk;
	tacc_sensor_model model (.clk(clk), .junction_temp(temp),
		.dac_threshold(dac_threshold), .sensor_temp(sensor_temp));
	tacc_thermal_ctrl dut (.clk(clk), .reset(reset),
		.spr_write(spr_write), .spr_read(spr_read), .spr_num(spr_num),
		.spr_wdata(spr_wdata), .spr_rdata(spr_rdata), .spr_hit(spr_hit),
		.sensor_temp(sensor_temp), .dac_threshold(dac_threshold),
		.external_irq_mask(mask), .thermal_irq(thermal_irq));
	function automatic tacc_word_t thw(input logic [6:0] t,
		input logic d, input logic e);
		thw = {2'h0, t, 20'h00000, d, e, 1'b1};
	endfunction : thw
	task automatic summarize;
		if (err_total == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	task automatic wr(input tacc_spr_t n, input tacc_word_t d);
		@(posedge clk);
		spr_write <= 1'b1;
		spr_num <= n;
		spr_wdata <= d;
		@(posedge clk);
		spr_write <= 1'b0;
	endtask : wr
	task automatic rd(input tacc_spr_t n, input tacc_word_t e,
		input logic h);
		@(posedge clk);
		spr_read <= 1'b1;
		spr_num <= n;
		@(posedge clk);
		spr_read <= 1'b0;
		#1;
		`CHK(spr_rdata, e)
		`CHK(spr_hit, h)
	endtask : rd
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : idle
	// Dual mode must present the lower threshold to the comparator
	always @(posedge clk) begin
		if (dac_threshold === 7'h46)
			seen_lo <= 1'b1;
	end
	// Longest path is about 560 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			summarize();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		rd(`TACC_SPR_UPPER, 32'h00000000, 1'b1);
		rd(`TACC_SPR_LOWER, 32'h00000000, 1'b1);
		rd(`TACC_SPR_CTRL, 32'h00000000, 1'b1);
		rd(10'h3FF, 32'h00000000, 1'b0);
		@(posedge clk);
		temp <= 7'h3C;
		mask <= 1'b1;
		wr(`TACC_SPR_UPPER, thw(7'h32, 1'b0, 1'b1) | 32'hC0000400);
		rd(`TACC_SPR_UPPER, thw(7'h32, 1'b0, 1'b1), 1'b1);
		// Short interval keeps the run brief
		wr(`TACC_SPR_CTRL, {18'h00000, 13'h0014, 1'b1});
		// Read in the last cycle before the sample lands, then just after
		idle(20);
		rd(`TACC_SPR_UPPER, thw(7'h32, 1'b0, 1'b1), 1'b1);
		rd(`TACC_SPR_UPPER, thw(7'h32, 1'b0, 1'b1) | fl_both, 1'b1);
		`CHK(dac_threshold, 7'h32)
		idle(60);
		rd(`TACC_SPR_UPPER, thw(7'h32, 1'b0, 1'b1) | fl_both, 1'b1);
		`CHK(thermal_irq, 1'b1)
		@(posedge clk) mask <= 1'b0;
		idle(4);
		`CHK(thermal_irq, 1'b0)
		wr(`TACC_SPR_UPPER, thw(7'h32, 1'b1, 1'b0));
		// Stale crossed flag stays, its valid flag drops
		rd(`TACC_SPR_UPPER, thw(7'h32, 1'b1, 1'b0) | fl_old, 1'b1);
		idle(60);
		rd(`TACC_SPR_UPPER, thw(7'h32, 1'b1, 1'b0) | fl_valid, 1'b1);
		@(posedge clk) temp <= 7'h1E;
		mask <= 1'b1;
		idle(60);
		rd(`TACC_SPR_UPPER, thw(7'h32, 1'b1, 1'b0) | fl_both, 1'b1);
		`CHK(thermal_irq, 1'b0)
		wr(`TACC_SPR_LOWER, thw(7'h46, 1'b0, 1'b1));
		idle(120);
		rd(`TACC_SPR_UPPER, thw(7'h32, 1'b1, 1'b0) | fl_both, 1'b1);
		rd(`TACC_SPR_LOWER, thw(7'h46, 1'b0, 1'b1) | fl_valid, 1'b1);
		`CHK(seen_lo, 1'b1)
		@(posedge clk) temp <= 7'h50;
		idle(120);
		`CHK(thermal_irq, 1'b1)
		wr(`TACC_SPR_CTRL, {18'h00000, 13'h0014, 1'b0});
		idle(60);
		rd(`TACC_SPR_UPPER, thw(7'h32, 1'b1, 1'b0), 1'b1);
		rd(`TACC_SPR_CTRL, 32'h00000028, 1'b1);
		`CHK(thermal_irq, 1'b0)
		summarize();
	end
endmodule : tacc_thermal_ctrl_tb
`default_nettype wire
